// [rtl/bph_dev_end.sv]
module bph_dev_end #(
  parameter int SYNC_MIN_CYC = bph_pkg::SYNC_MIN_CYC
) (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // programming pin
  bph_link_if.dev                         lnk,
  // measured angle
  input  wire logic [bph_pkg::PWM_W-1:0]  i_angle,
  // status
  output logic                            o_prog,
  output logic                            o_lock,
  output logic [7:0]                      o_err_code
);

  // ****************************************
  // checks
  // ****************************************
  if ((SYNC_MIN_CYC <= (1 << bph_pkg::PWM_W)) || (SYNC_MIN_CYC >= (1 << bph_pkg::CNT_W))) begin : g_chk
    $error("sync threshold must exceed the pwm period and fit the counter");
  end

  localparam logic [bph_pkg::CNT_W-1:0] SYNC_LIM = SYNC_MIN_CYC[bph_pkg::CNT_W-1:0] - bph_pkg::CNT_ONE;

  typedef enum {D_APP, D_SYNC, D_IDLE, D_RX, D_TURN, D_TX} bph_dst_t;

  typedef struct packed {
    bph_dst_t                                                   st;
    bph_pkg::bph_lane_t                                         ln;
    logic                                                       prev;
    logic                                                       oe;
    logic                                                       drv;
    logic [bph_pkg::PWM_W-1:0]                                  pwm;
    logic [bph_pkg::MEM_WORDS-1:0][bph_pkg::DATA_W-1:0]        mem;
    logic                                                       lock;
    logic [7:0]                                                 err;
    logic                                                       prog;
  } bph_dev_t;

  bph_dev_t s;
  bph_dev_t next_s;
  logic     edge_seen;

  assign edge_seen = lnk.line ^ s.prev;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    bph_pkg::bph_req_t req;
    bph_pkg::bph_rsp_t rsp;
    req = bph_pkg::bph_req_t'(s.ln.sh);
    rsp = '0;
    next_s = s;
    next_s.prev = lnk.line;
    unique case (s.st)
      D_APP: begin
        next_s.oe = 1'b1;
        next_s.pwm = s.pwm + 1'b1;
        next_s.drv = (s.pwm <= i_angle);
        next_s.ln.cnt = lnk.line ? '0 : s.ln.cnt + bph_pkg::CNT_ONE;
        // own low phase never reaches the threshold, only a forced one does
        if (!lnk.line && (s.ln.cnt >= SYNC_LIM)) begin
          next_s.st = D_SYNC;
          next_s.oe = 1'b0;
          next_s.drv = 1'b1;
        end
      end
      D_SYNC: begin
        if (lnk.line) begin
          next_s.st = D_IDLE;
          next_s.prog = 1'b1;
        end
      end
      D_IDLE: begin
        if (edge_seen && !lnk.line) begin
          next_s.st = D_RX;
          next_s.ln = '0;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
        end
      end
      D_RX: begin
        next_s.ln = bph_pkg::bph_rx_step(s.ln, edge_seen);
        if (next_s.ln.err) begin
          next_s.st = D_IDLE;
          next_s.err = edge_seen ? bph_pkg::ERR_CODING : bph_pkg::ERR_TIMEOUT;
        end else if (next_s.ln.done) begin
          req = bph_pkg::bph_req_t'(next_s.ln.sh);
          rsp.status = bph_pkg::ST_ACK;
          unique case (req.op)
            bph_pkg::OP_READ: begin
              rsp.data = s.mem[req.addr];
            end
            bph_pkg::OP_WRITE: begin
              if (s.lock) begin
                rsp.status = bph_pkg::ST_NAK;
              end else begin
                next_s.mem[req.addr] = req.data;
              end
            end
            bph_pkg::OP_LOCK: begin
              next_s.lock = 1'b1;
              rsp.data = 8'h01;
            end
            bph_pkg::OP_STAT: begin
              if (req.addr == bph_pkg::STAT_ANGLE) begin
                rsp.data = i_angle;
              end else if (req.addr == bph_pkg::STAT_ERR) begin
                rsp.data = s.err;
              end else if (req.addr == bph_pkg::STAT_LOCK) begin
                rsp.data = {7'h00, s.lock};
              end else begin
                rsp.status = bph_pkg::ST_BAD;
              end
            end
          endcase
          next_s.ln.sh = rsp;
          next_s.st = D_TURN;
        end
      end
      D_TURN: begin
        // two periods of quiet let the host finish its held bit and let go
        next_s.ln.cnt = s.ln.cnt + bph_pkg::CNT_ONE;
        if (bph_pkg::bph_late(s.ln.cnt, s.ln.per)) begin
          next_s.st = D_TX;
          next_s.oe = 1'b1;
          next_s.drv = 1'b0;
          next_s.ln.drv = 1'b0;
          next_s.ln.bitn = 5'h00;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
        end
      end
      D_TX: begin
        next_s.ln = bph_pkg::bph_tx_step(s.ln);
        next_s.drv = next_s.ln.drv;
        if (next_s.ln.done) begin
          next_s.oe = 1'b0;
          next_s.st = D_IDLE;
        end
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lnk.dev_drv = s.drv;
  assign lnk.dev_oe  = s.oe;
  assign o_prog      = s.prog;
  assign o_lock      = s.lock;
  assign o_err_code  = s.err;

endmodule // bph_dev_end

module bph_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // fill side
  input  wire logic          i_in_valid,
  input  wire logic [W-1:0]  i_in_data,
  output logic               o_in_ready,
  // drain side
  output logic               o_out_valid,
  output logic [W-1:0]       o_out_data,
  input  wire logic          i_out_ready
);

  // ****************************************
  // checks
  // ****************************************
  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0) || (W < 1)) begin : g_chk
    $error("fifo depth must be a power of two of at least two");
  end

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
    logic                    vld;
  } bph_fifo_t;

  bph_fifo_t s;
  bph_fifo_t next_s;
  logic      push;
  logic      pop;

  assign push = i_in_valid && s.rdy;
  assign pop  = i_out_ready && s.vld;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = i_in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) next_s.rp = s.rp + 1'b1;
    unique case ({push, pop})
      2'b10: next_s.cnt = s.cnt + 1'b1;
      2'b01: next_s.cnt = s.cnt - 1'b1;
      default: next_s.cnt = s.cnt;
    endcase
    // flags registered so that both sides see honest full and empty
    next_s.rdy = (next_s.cnt != FULL_CNT);
    next_s.vld = (next_s.cnt != '0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_in_ready  = s.rdy;
  assign o_out_valid = s.vld;
  assign o_out_data  = s.mem[s.rp];

endmodule // bph_fifo

// [rtl/bph_pkg.sv]
package bph_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ        = 10_000_000;
  localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int BIT_MIN_NS    = 10_000;
  localparam int BIT_MAX_NS    = 1_100_000;
  localparam int BIT_MIN_CYC   = (BIT_MIN_NS * CYC_PER_US + 999) / 1000;
  localparam int BIT_MAX_CYC   = (BIT_MAX_NS * CYC_PER_US) / 1000;
  localparam int BIT_DEF_CYC   = 1000;
  localparam int SYNC_MIN_US   = 1500;
  localparam int SYNC_MIN_CYC  = SYNC_MIN_US * CYC_PER_US;
  localparam int SYNC_HOST_US  = 2000;
  localparam int SYNC_HOST_CYC = SYNC_HOST_US * CYC_PER_US;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int CNT_W      = 20;
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 6;
  localparam int DATA_W     = 8;
  localparam int MEM_WORDS  = 64;
  localparam int FIFO_DEPTH = 32;
  localparam int PWM_W      = 8;

  localparam logic [CNT_W-1:0] CNT_ONE   = 20'h0_0001;
  localparam logic [CNT_W-1:0] START_LIM = CNT_W'(2 * BIT_MAX_CYC);
  localparam logic [4:0]       BIT_LAST  = 5'h10;
  localparam logic [4:0]       BIT_HOLD  = 5'h11;

  // ****************************************
  // telegram layout and codes
  // ****************************************
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_LOCK, OP_STAT} bph_op_t;

  typedef struct packed {
    bph_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } bph_req_t;

  typedef struct packed {
    logic [7:0]          status;
    logic [DATA_W-1:0]   data;
  } bph_rsp_t;

  localparam logic [7:0]        ST_ACK      = 8'h06;
  localparam logic [7:0]        ST_NAK      = 8'h15;
  localparam logic [7:0]        ST_BAD      = 8'h18;
  localparam logic [7:0]        ERR_TIMEOUT = 8'h01;
  localparam logic [7:0]        ERR_CODING  = 8'h02;
  localparam logic [ADDR_W-1:0] STAT_ANGLE  = 6'h00;
  localparam logic [ADDR_W-1:0] STAT_ERR    = 6'h01;
  localparam logic [ADDR_W-1:0] STAT_LOCK   = 6'h02;

  // one serial lane, shared by receiver and transmitter
  typedef struct packed {
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    per;
    logic [4:0]          bitn;
    logic                mid;
    logic [WORD_W-1:0]   sh;
    logic                drv;
    logic                done;
    logic                err;
  } bph_lane_t;

  // ****************************************
  // coding functions
  // ****************************************
  function automatic logic bph_is_mid(input logic [CNT_W-1:0] t, input logic [CNT_W-1:0] p);
    return t < (p - (p >> 2));
  endfunction

  function automatic logic bph_late(input logic [CNT_W-1:0] t, input logic [CNT_W-1:0] p);
    return t > {p[CNT_W-2:0], 1'b0};
  endfunction

  // bit 0 of a frame is a zero that calibrates the period
  function automatic bph_lane_t bph_rx_step(input bph_lane_t l, input logic edge_seen);
    bph_lane_t n;
    n = l;
    n.done = 1'b0;
    n.err = 1'b0;
    if (l.cnt != '1) n.cnt = l.cnt + CNT_ONE;
    if (edge_seen) begin
      if (l.bitn == 5'h00) begin
        n.per = l.cnt;
        n.bitn = 5'h01;
        n.mid = 1'b0;
        n.cnt = CNT_ONE;
      end else if (bph_is_mid(l.cnt, l.per)) begin
        n.err = l.mid;
        n.mid = 1'b1;
      end else begin
        n.sh = {l.sh[WORD_W-2:0], l.mid};
        n.mid = 1'b0;
        n.bitn = l.bitn + 5'h01;
        n.cnt = CNT_ONE;
        n.done = (l.bitn == BIT_LAST);
      end
    end else if (l.bitn == 5'h00) begin
      n.err = (l.cnt > START_LIM);
    end else begin
      n.err = bph_late(l.cnt, l.per);
    end
    return n;
  endfunction

  // start bit, sixteen data bits msb first, then one held period
  function automatic bph_lane_t bph_tx_step(input bph_lane_t l);
    bph_lane_t n;
    n = l;
    n.done = 1'b0;
    n.err = 1'b0;
    n.cnt = l.cnt + CNT_ONE;
    if ((l.bitn != 5'h00) && (l.bitn <= BIT_LAST) && l.sh[WORD_W-1] && (l.cnt == (l.per >> 1))) begin
      n.drv = ~l.drv;
    end
    if (l.cnt == l.per) begin
      n.cnt = CNT_ONE;
      if (l.bitn == BIT_HOLD) begin
        n.done = 1'b1;
      end else begin
        n.drv = ~l.drv;
        n.bitn = l.bitn + 5'h01;
        if (l.bitn != 5'h00) n.sh = {l.sh[WORD_W-2:0], 1'b0};
      end
    end
    return n;
  endfunction

endpackage

// [rtl/bph_link_if.sv]
interface bph_link_if;

  // ****************************************
  // single output pin, pulled high when free
  // ****************************************
  logic host_drv;
  logic host_oe;
  logic dev_drv;
  logic dev_oe;
  logic line;

  // the host overdrives the sensor output, as a stiff programmer does
  assign line = host_oe ? host_drv : (dev_oe ? dev_drv : 1'b1);

  modport host (output host_drv, output host_oe, input line);
  modport dev  (output dev_drv, output dev_oe, input line);

endinterface

// [rtl/bph_host_end.sv]

module bph_host_end #(
  parameter int BIT_CYC  = bph_pkg::BIT_DEF_CYC,
  parameter int SYNC_CYC = bph_pkg::SYNC_HOST_CYC,
  parameter int DEPTH    = bph_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  // programming pin
  bph_link_if.host                         lnk,
  // control
  input  wire logic                        i_enter,
  output logic                             o_prog,
  // telegram queue
  input  wire logic                        i_req_valid,
  input  wire logic [bph_pkg::WORD_W-1:0]  i_req_data,
  output logic                             o_req_ready,
  // replies
  output logic                             o_rsp_valid,
  output logic [bph_pkg::WORD_W-1:0]       o_rsp_data,
  output logic                             o_rsp_ack,
  output logic                             o_rsp_err,
  output logic                             o_locked
);

  // ****************************************
  // checks
  // ****************************************
  if ((BIT_CYC < bph_pkg::BIT_MIN_CYC) || (BIT_CYC > bph_pkg::BIT_MAX_CYC)) begin : g_chk_bit
    $error("bit period outside the range the sensor accepts");
  end
  if ((SYNC_CYC < 1) || (SYNC_CYC >= (1 << bph_pkg::CNT_W))) begin : g_chk_sync
    $error("sync length must fit the counter");
  end

  localparam logic [bph_pkg::CNT_W-1:0] PER      = BIT_CYC[bph_pkg::CNT_W-1:0];
  localparam logic [bph_pkg::CNT_W-1:0] SYNC_LIM = SYNC_CYC[bph_pkg::CNT_W-1:0];
  localparam logic [bph_pkg::CNT_W-1:0] GAP_LIM  = PER + PER;
  localparam logic [bph_pkg::CNT_W-1:0] RSP_WAIT = GAP_LIM + GAP_LIM;

  typedef enum {H_OFF, H_SYNC, H_GAP, H_READY, H_TX, H_ARM, H_RX} bph_hst_t;

  typedef struct packed {
    bph_hst_t                        st;
    bph_pkg::bph_lane_t              ln;
    logic                            prev;
    logic                            oe;
    logic                            drv;
    logic                            prog;
    logic                            lock_sent;
    logic                            verify_due;
    logic                            verifying;
    logic                            locked;
    logic                            rsp_valid;
    logic [bph_pkg::WORD_W-1:0]      rsp_data;
    logic                            rsp_ack;
    logic                            rsp_err;
  } bph_host_t;

  bph_host_t                   s;
  bph_host_t                   next_s;
  logic                        edge_seen;
  logic                        f_valid;
  logic [bph_pkg::WORD_W-1:0]  f_data;
  logic                        pop;

  assign edge_seen = lnk.line ^ s.prev;
  // a pending lock readback takes the slot before the next queued word
  assign pop = (s.st == H_READY) && !s.verify_due && f_valid;

  // ****************************************
  // telegram queue
  // ****************************************
  bph_fifo #(
    .W     (bph_pkg::WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_req_valid),
    .i_in_data   (i_req_data),
    .o_in_ready  (o_req_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (pop)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    bph_pkg::bph_req_t req;
    bph_pkg::bph_rsp_t rsp;
    req = bph_pkg::bph_req_t'(f_data);
    rsp = bph_pkg::bph_rsp_t'(s.ln.sh);
    next_s = s;
    next_s.prev = lnk.line;
    next_s.rsp_valid = 1'b0;
    unique case (s.st)
      H_OFF: begin
        if (i_enter) begin
          next_s.st = H_SYNC;
          next_s.oe = 1'b1;
          next_s.drv = 1'b0;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
        end
      end
      H_SYNC: begin
        next_s.ln.cnt = s.ln.cnt + bph_pkg::CNT_ONE;
        if (s.ln.cnt >= SYNC_LIM) begin
          next_s.st = H_GAP;
          next_s.oe = 1'b0;
          next_s.drv = 1'b1;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
        end
      end
      H_GAP: begin
        next_s.ln.cnt = s.ln.cnt + bph_pkg::CNT_ONE;
        if (s.ln.cnt >= GAP_LIM) begin
          next_s.st = H_READY;
          next_s.prog = 1'b1;
        end
      end
      H_READY: begin
        if (s.verify_due || f_valid) begin
          next_s.st = H_TX;
          next_s.oe = 1'b1;
          next_s.drv = 1'b0;
          next_s.ln.drv = 1'b0;
          next_s.ln.bitn = 5'h00;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
          next_s.ln.per = PER;
          if (s.verify_due) begin
            next_s.ln.sh = {bph_pkg::OP_STAT, bph_pkg::STAT_LOCK, 8'h00};
            next_s.verify_due = 1'b0;
            next_s.verifying = 1'b1;
          end else begin
            // queued words leave in order, so readbacks queued after the lock go out behind it
            next_s.ln.sh = f_data;
            next_s.lock_sent = (req.op == bph_pkg::OP_LOCK);
            next_s.verifying = 1'b0;
          end
        end
      end
      H_TX: begin
        next_s.ln = bph_pkg::bph_tx_step(s.ln);
        next_s.drv = next_s.ln.drv;
        if (next_s.ln.done) begin
          next_s.st = H_ARM;
          next_s.oe = 1'b0;
          next_s.drv = 1'b1;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
        end
      end
      H_ARM: begin
        next_s.ln.cnt = s.ln.cnt + bph_pkg::CNT_ONE;
        if (edge_seen && !lnk.line) begin
          next_s.st = H_RX;
          next_s.ln = '0;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
        end else if (s.ln.cnt >= RSP_WAIT) begin
          next_s.st = H_GAP;
          next_s.rsp_valid = 1'b1;
          next_s.rsp_err = 1'b1;
          next_s.rsp_ack = 1'b0;
          next_s.verifying = 1'b0;
          next_s.lock_sent = 1'b0;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
        end
      end
      H_RX: begin
        next_s.ln = bph_pkg::bph_rx_step(s.ln, edge_seen);
        rsp = bph_pkg::bph_rsp_t'(next_s.ln.sh);
        if (next_s.ln.err || next_s.ln.done) begin
          next_s.st = H_GAP;
          next_s.rsp_valid = 1'b1;
          next_s.rsp_err = next_s.ln.err;
          next_s.rsp_data = next_s.ln.sh;
          next_s.rsp_ack = !next_s.ln.err && (rsp.status == bph_pkg::ST_ACK);
          next_s.verifying = 1'b0;
          next_s.lock_sent = 1'b0;
          next_s.ln.cnt = bph_pkg::CNT_ONE;
          if (s.verifying && !next_s.ln.err) begin
            next_s.locked = (rsp.status == bph_pkg::ST_ACK) && rsp.data[0];
          end
          if (s.lock_sent && !next_s.ln.err && (rsp.status == bph_pkg::ST_ACK)) begin
            next_s.verify_due = 1'b1;
          end
        end
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lnk.host_drv = s.drv;
  assign lnk.host_oe  = s.oe;
  assign o_prog       = s.prog;
  assign o_rsp_valid  = s.rsp_valid;
  assign o_rsp_data   = s.rsp_data;
  assign o_rsp_ack    = s.rsp_ack;
  assign o_rsp_err    = s.rsp_err;
  assign o_locked     = s.locked;

endmodule // bph_host_end

// [test/bph_properties.sv]
module bph_properties #(
  parameter int P  = 100,
  parameter int SM = 400,
  parameter int SH = 500
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // pin
  input wire logic host_drv,
  input wire logic host_oe,
  input wire logic dev_drv,
  input wire logic dev_oe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // edge gaps and drive lengths
  // ****
  logic        prog;
  logic [15:0] gh, gd, hc, dc, lc;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog <= 1'b0;
      gh <= '0;
      gd <= '0;
      hc <= '0;
      dc <= '0;
      lc <= '0;
    end else begin
      prog <= prog | $fell(host_oe);
      gh <= ($changed(host_drv) || !host_oe) ? 16'h0001 : gh + 16'h0001;
      gd <= ($changed(dev_drv) || !dev_oe) ? 16'h0001 : gd + 16'h0001;
      hc <= host_oe ? hc + 16'h0001 : '0;
      dc <= dev_oe ? dc + 16'h0001 : '0;
      lc <= line ? '0 : lc + 16'h0001;
    end
  end
  // gaps allow one cycle of slack for where the start edge is counted
  a_host_gap: assert property (host_oe && $past(host_oe) && $changed(host_drv) |->
    gh inside {[P/2-1:P/2+1], [P-1:P+1]}) else $error("host edge spacing wrong");
  a_dev_gap: assert property (prog && dev_oe && $past(dev_oe) && $changed(dev_drv) |->
    gd inside {[P/2-1:P/2+1], [P-1:P+1]}) else $error("sensor edge spacing wrong");
  a_sync_len: assert property ($fell(host_oe) && !prog |-> hc inside {[SH-1:SH+1]})
    else $error("sync pulse length wrong");
  a_frame_len: assert property ($fell(host_oe) && prog |-> hc inside {[18*P-1:18*P+1]})
    else $error("host frame length wrong");
  a_reply_len: assert property ($fell(dev_oe) && prog |-> dc inside {[18*P-1:18*P+1]})
    else $error("reply length wrong");
  a_sync_take: assert property ($fell(dev_oe) && !prog |-> lc inside {[SM-1:SM+2]})
    else $error("sensor left application mode early");
  a_app_drive: assert property (!prog && !host_oe && !$past(host_oe) && $past(i_rst_n) |-> dev_oe)
    else $error("sensor not driving in application mode");
  a_reply_start: assert property ($rose(dev_oe) && prog |-> !dev_drv && !host_oe && $past(line))
    else $error("reply start wrong");
endmodule // bph_properties

// [test/tb.sv]
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // 24-word queue session over the pin
  // ****
  localparam int P = 100;
  logic        i_clk, i_rst_n, i_enter, i_req_valid, o_req_ready, o_prog, d_prog, d_lock;
  logic        o_rsp_valid, o_rsp_ack, o_rsp_err, o_locked, lk;
  logic [15:0] i_req_data, o_rsp_data, w;
  logic [7:0]  i_angle, o_err_code;
  logic [7:0]  mem [64];
  logic        known [64];
  logic [5:0]  wa [8];
  logic [5:0]  sa [4] = '{6'h00, 6'h01, 6'h02, 6'h05};
  logic [16:0] e;
  logic [16:0] exp_q [$];
  int          errors, checks, got, n;

  bph_link_if lnk ();
  bph_dev_end #(.SYNC_MIN_CYC(400)) i_bph_dev_end (.i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(lnk),
    .i_angle(i_angle), .o_prog(d_prog), .o_lock(d_lock), .o_err_code(o_err_code));
  bph_host_end #(.BIT_CYC(P), .SYNC_CYC(500), .DEPTH(32)) i_bph_host_end (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .lnk(lnk), .i_enter(i_enter), .o_prog(o_prog), .i_req_valid(i_req_valid), .i_req_data(i_req_data),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_rsp_ack(o_rsp_ack),
    .o_rsp_err(o_rsp_err), .o_locked(o_locked));
  bph_properties #(.P(P), .SM(400), .SH(500)) i_bph_properties (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .host_drv(lnk.host_drv), .host_oe(lnk.host_oe), .dev_drv(lnk.dev_drv), .dev_oe(lnk.dev_oe), .line(lnk.line));

  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // writes, status corners, lock, refused rewrites, readbacks
  task automatic next_word(input int k);
    logic [5:0] a;
    a = 6'($urandom);
    w = {2'h1, a, 8'($urandom)};
    if (k < 8) wa[k] = a;
    else if (k < 12) w = {2'h3, sa[k-8], 8'h00};
    else if (k == 12) w = 16'h8000;
    else if (k < 20) w[13:8] = wa[k-13];
    else if (k < 28) w = {2'h0, wa[k-20], 8'h00};
    else w = {2'h0, a, 8'h00};
    i_req_data = w;
    a = w[13:8];
    case (w[15:14])
      2'h0: exp_q.push_back({known[a], bph_pkg::ST_ACK, mem[a]});
      2'h1: begin
        exp_q.push_back({1'b0, lk ? bph_pkg::ST_NAK : bph_pkg::ST_ACK, 8'h00});
        if (!lk) mem[a] = w[7:0];
        if (!lk) known[a] = 1'b1;
      end
      2'h2: begin
        lk = 1'b1;
        repeat (2) exp_q.push_back({1'b1, bph_pkg::ST_ACK, 8'h01});
      end
      default: exp_q.push_back(a == bph_pkg::STAT_ANGLE ? {1'b1, bph_pkg::ST_ACK, i_angle} :
        a == bph_pkg::STAT_ERR ? {1'b1, bph_pkg::ST_ACK, 8'h00} :
        a == bph_pkg::STAT_LOCK ? {1'b1, bph_pkg::ST_ACK, 7'h00, lk} : {1'b0, bph_pkg::ST_BAD, 8'h00});
    endcase
  endtask

  always @(negedge i_clk) begin
    if (o_rsp_valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      e = exp_q.pop_front();
      got++;
      `CHK(o_rsp_data[15:8], e[15:8])
      if (e[16]) `CHK(o_rsp_data[7:0], e[7:0])
      `CHK(o_rsp_ack, e[15:8] == bph_pkg::ST_ACK)
      `CHK(o_rsp_err, 1'b0)
    end
  end

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    i_enter = 1'b0;
    i_req_valid = 1'b0;
    i_req_data = '0;
    lk = 1'b0;
    known = '{default: 1'b0};
    void'($urandom(12));
    i_angle = 8'($urandom);
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK(lnk.dev_oe, 1'b1)
    `CHK(d_prog, 1'b0)
    `CHK(o_prog, 1'b0)
    // words wait in the queue until the link is up, so it fills
    for (n = 0; n < 32; n++) begin
      `CHK(o_req_ready, 1'b1)
      i_req_data = 16'($urandom);
      i_req_valid = 1'b1;
      @(negedge i_clk);
    end
    i_req_valid = 1'b0;
    `CHK(o_req_ready, 1'b0)
    // a reset in mid-run flushes the queue and restarts application mode
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK(o_req_ready, 1'b1)
    `CHK(lnk.dev_oe, 1'b1)
    // a shorter session keeps the whole run inside its cycle budget
    for (n = 0; n < 24; n++) begin
      `CHK(o_req_ready, 1'b1)
      next_word(n);
      i_req_valid = 1'b1;
      @(negedge i_clk);
    end
    i_req_valid = 1'b0;
    i_enter = 1'b1;
    @(negedge i_clk);
    i_enter = 1'b0;
    for (n = 0; n < 1000 && d_prog !== 1'b1; n++) @(negedge i_clk);
    `CHK(d_prog, 1'b1)
    for (n = 0; n < 99000 && got < 25; n++) @(negedge i_clk);
    `CHK(got, 25)
    `CHK(o_locked, 1'b1)
    `CHK(d_lock, 1'b1)
    `CHK(o_err_code, 8'h00)
    `CHK(o_prog, 1'b1)
    `CHK(o_req_ready, 1'b1)
    conclude();
  end
endmodule // tb
